/* tlw_pkg.sv */
// Shared constants and types for the temperature table and write-protect block
package tlw_pkg;

    // ************************************************
    // Device addresses and memory layout
    // ************************************************
    localparam logic [7:0] AUX_ADDR       = 8'ha0;
    localparam logic [7:0] MAIN_ADDR_DFLT = 8'ha2;
    localparam logic [7:0] TABLE_BASE     = 8'h80;
    localparam logic [7:0] SRAM_LO        = 8'h60;
    localparam logic [7:0] TABLE_SEL_OFS  = 8'h7f;
    localparam logic [7:0] MAN_POS0_OFS   = 8'h82;
    localparam logic [7:0] MAN_POS1_OFS   = 8'h83;
    localparam logic [7:0] PROT_CFG_OFS   = 8'h89;
    localparam logic [7:0] PROG_ADDR_OFS  = 8'h8c;
    localparam logic [7:0] TBL_EXTRA      = 8'h00;
    localparam logic [7:0] TBL_CONFIG     = 8'h01;
    localparam logic [7:0] TBL_LUT0       = 8'h02;
    localparam logic [7:0] TBL_LUT1       = 8'h03;

    // ************************************************
    // Configuration bit positions in byte 89h
    // ************************************************
    localparam int CFG_TEMP_EN_BIT = 0;
    localparam int CFG_SINGLE_BIT  = 1;
    localparam int CFG_PROGADR_BIT = 2;
    localparam int CFG_AUXPROT_BIT = 3;
    localparam int CFG_MAINPROT_BIT = 4;
    localparam logic [7:0] CFG_RESET = 8'h01;

    // ************************************************
    // Look-up index limits
    // ************************************************
    localparam logic [7:0] LUT_IDX_MIN   = 8'h80;
    localparam logic [7:0] LUT_IDX_MAX   = 8'hc7;
    localparam logic signed [8:0] TEMP_MIN_C = -9'sd40;
    localparam int STEP_SHIFT = 1;
    localparam int SYNC_STAGES = 3;

    // Host byte write request
    typedef struct packed {
        logic       valid;
        logic [7:0] dev_addr;
        logic [7:0] offset;
        logic [7:0] data;
    } tlw_req_t;

    // Resistor positions
    typedef struct packed {
        logic [7:0] pos0;
        logic [7:0] pos1;
    } tlw_pos_t;

endpackage

/* tlw_pin_sync.sv */
// Three-stage synchroniser for the protect pin with agreement filter
`timescale 1ns/1ps
module tlw_pin_sync
    import tlw_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sh;
        logic                   lvl;
    } tlw_sync_st_t;

    tlw_sync_st_t st_q;
    tlw_sync_st_t st_d;

    // *********************************
    // Next state
    // *********************************
    always_comb begin
        st_d = st_q;
        st_d.sh = {st_q.sh[SYNC_STAGES-2:0], pin_i};
        // Only stages two and three take part; stage one feeds stage two alone
        if (st_q.sh[1] == st_q.sh[2]) begin
            st_d.lvl = st_q.sh[2];
        end
    end

    // Registers, reset to the pulled-up level
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q <= '{sh: {SYNC_STAGES{RESET_VAL}}, lvl: RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;

endmodule

/* tlw_lut_index.sv */
// Temperature to look-up index mapper
`timescale 1ns/1ps
module tlw_lut_index
    import tlw_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Temperature word, two's complement, 1/256 degree
    input  wire logic [15:0] temp_i,
    output logic [7:0]       index_o
);

    typedef struct packed {
        logic [7:0] idx;
    } tlw_idx_st_t;

    tlw_idx_st_t st_q;
    tlw_idx_st_t st_d;

    logic signed [9:0] rel_c;

    // *********************************
    // Index arithmetic
    // *********************************
    always_comb begin
        st_d = st_q;
        // Offset from -40 in whole degrees; fraction discarded
        rel_c = 10'(signed'(temp_i[15:8])) - 10'(TEMP_MIN_C);
        if (rel_c < 10'sd0) begin
            st_d.idx = LUT_IDX_MIN;
        end else if ((rel_c >>> STEP_SHIFT) > 10'(LUT_IDX_MAX - LUT_IDX_MIN)) begin
            st_d.idx = LUT_IDX_MAX;
        end else begin
            st_d.idx = LUT_IDX_MIN + 8'(rel_c >>> STEP_SHIFT);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q <= '{idx: LUT_IDX_MIN};
        end else begin
            st_q <= st_d;
        end
    end

    assign index_o = st_q.idx;

    // Index always inside the table
    idx_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        index_o >= LUT_IDX_MIN && index_o <= LUT_IDX_MAX)
        else $error("lut index out of range");
    // Cold clamp
    idx_cold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        signed'(temp_i[15:8]) < -8'sd40 |=> index_o == LUT_IDX_MIN)
        else $error("cold clamp wrong");
    // Hot clamp
    idx_hot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        signed'(temp_i[15:8]) > 8'sd103 |=> index_o == LUT_IDX_MAX)
        else $error("hot clamp wrong");

endmodule

/* tlw_core.sv */
// Address decode, table select, write protection and resistor selection
// How it works
// - Resistor settings come from a table entry 80h..C7h indexed in 2 degree steps.
// - Each entry holds separate full-byte positions for resistor 0 and resistor 1.
// - With temperature indexing off, positions come from config bytes 82h and 83h.
// - Monitor inputs pass through as unsigned 16-bit codes, 38.147 uV per count.
// - Temperature is 16-bit two's complement, whole degrees high, 1/256 low.
// - Dual mode answers A0h and main; single mode answers main only.
// - Main address is A2h, or the programmed byte 8Ch when selected.
// - Bytes 80h and up reachable only via main; table chosen by byte 7Fh.
// - Single mode exposes extra 128 EEPROM bytes as table 00 via main.
// - Protect bits in byte 89h writable only through the main address.
// - Main writes below 60h (except read-only 04h..07h) and to tables 01..03 blocked exactly when pin high and main protect bit set.
// - Auxiliary writes blocked whenever auxiliary protect bit is set.
// - Table 00 protection follows the auxiliary protect bit, ignoring the pin.
// - Main bytes 60h to 7Fh are never write protected.
// - Reserved SRAM bytes accept writes as scratch storage.
// - Writes only land when unprotected; read-only bytes never accept writes.
// - Programmed address byte defaults to A2h.
// - Protect pin idles high; a low pin removes main protection.
`timescale 1ns/1ps
module tlw_core
    import tlw_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Host write request, one byte per cycle
    input  wire tlw_req_t    req_i,
    // Host read request, combinational decode
    input  wire logic [7:0]  rd_dev_i,
    input  wire logic [7:0]  rd_ofs_i,
    output logic [7:0]       rd_data_o,
    output logic             rd_hit_o,
    // Write answer
    output logic             wr_ack_o,
    output logic             wr_done_o,
    // Protect pin, internally pulled up
    input  wire logic        protect_pin_i,
    // Monitor and temperature readings
    input  wire logic [15:0] temp_i,
    input  wire logic [15:0] ext_monitor_a_i,
    input  wire logic [15:0] ext_monitor_b_i,
    input  wire logic [15:0] ext_monitor_c_i,
    // Resistor positions
    output tlw_pos_t         pos_o,
    output logic [7:0]       main_addr_o
);

    // *********************************
    // State
    // *********************************
    typedef struct packed {
        logic [7:0] tbl_sel;
        logic [7:0] cfg;
        logic [7:0] prog_addr;
        logic [7:0] man0;
        logic [7:0] man1;
        tlw_pos_t   pos;
        logic       ack;
        logic       done;
    } tlw_core_st_t;

    tlw_core_st_t st_q;
    tlw_core_st_t st_d;

    // Main and table memories, sized to their documented spans
    logic [7:0] aux_mem  [128];
    logic [7:0] extra_mem[128];
    logic [7:0] cfg_mem  [128];
    logic [7:0] lut0_mem [72];
    logic [7:0] lut1_mem [72];
    logic [7:0] main_mem [96];
    logic [7:0] sram_mem [32];

    logic       pin_lvl;
    logic [7:0] lut_idx;
    logic [7:0] main_addr_c;
    logic       single_c;
    logic       hit_main_w;
    logic       hit_aux_w;
    logic       prot_main_c;
    logic       prot_aux_c;
    logic       wr_ok_c;
    logic       ro_c;
    logic [6:0] lo7;
    logic [1:0] wr_hit_c;

    // Address match for a device byte under the current config
    function automatic logic [1:0] dev_hit(input logic [7:0] dev, input logic [7:0] cfg,
                                           input logic [7:0] padr);
        logic [7:0] m;
        m = cfg[CFG_PROGADR_BIT] ? padr : MAIN_ADDR_DFLT;
        dev_hit = {dev[7:1] == m[7:1], (dev[7:1] == AUX_ADDR[7:1]) && !cfg[CFG_SINGLE_BIT]};
    endfunction

    // Read-only bytes of the main low space: measured values and reserved words
    function automatic logic main_ro(input logic [7:0] ofs);
        main_ro = (ofs >= 8'h04 && ofs <= 8'h07) || (ofs >= 8'h60 && ofs <= 8'h69);
    endfunction

    tlw_pin_sync #(.RESET_VAL(1'b1)) u_pin (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (protect_pin_i),
        .level_o   (pin_lvl)
    );

    tlw_lut_index u_idx (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .temp_i    (temp_i),
        .index_o   (lut_idx)
    );

    // *********************************
    // Write decode and protection
    // *********************************
    always_comb begin
        single_c    = st_q.cfg[CFG_SINGLE_BIT];
        main_addr_c = st_q.cfg[CFG_PROGADR_BIT] ? st_q.prog_addr : MAIN_ADDR_DFLT;
        // Decode once into a variable, since a select on a call result is not legal
        wr_hit_c    = dev_hit(req_i.dev_addr, st_q.cfg, st_q.prog_addr);
        hit_main_w  = req_i.valid && wr_hit_c == 2'b10;
        hit_aux_w   = req_i.valid && wr_hit_c[0];
        prot_main_c = pin_lvl && st_q.cfg[CFG_MAINPROT_BIT];
        prot_aux_c  = st_q.cfg[CFG_AUXPROT_BIT];
        lo7         = req_i.offset[6:0];
        ro_c        = 1'b0;
        wr_ok_c     = 1'b0;
        if (hit_aux_w) begin
            // Aux space sees only 00..7F; high half of its byte space is not there
            wr_ok_c = !prot_aux_c && !req_i.offset[7];
        end else if (hit_main_w) begin
            if (req_i.offset >= SRAM_LO && req_i.offset < TABLE_BASE) begin
                ro_c    = main_ro(req_i.offset);
                wr_ok_c = !ro_c;
            end else if (!req_i.offset[7]) begin
                ro_c    = main_ro(req_i.offset);
                wr_ok_c = !ro_c && !prot_main_c;
            end else if (st_q.tbl_sel == TBL_EXTRA) begin
                wr_ok_c = single_c && !prot_aux_c;
            end else if (st_q.tbl_sel == TBL_CONFIG || st_q.tbl_sel == TBL_LUT0 ||
                         st_q.tbl_sel == TBL_LUT1) begin
                wr_ok_c = !prot_main_c;
            end
        end
    end

    // *********************************
    // Register next state and resistor selection
    // *********************************
    always_comb begin
        st_d = st_q;
        // Acknowledge any addressed write even when the data is dropped
        st_d.ack  = hit_main_w || hit_aux_w;
        st_d.done = wr_ok_c;
        if (wr_ok_c && hit_main_w) begin
            if (req_i.offset == TABLE_SEL_OFS) begin
                st_d.tbl_sel = req_i.data;
            end
            if (req_i.offset[7] && st_q.tbl_sel == TBL_CONFIG) begin
                // Only main can reach table 01, so protect bits never change via aux
                case (req_i.offset)
                    PROT_CFG_OFS:  st_d.cfg       = req_i.data;
                    PROG_ADDR_OFS: st_d.prog_addr = req_i.data;
                    MAN_POS0_OFS:  st_d.man0      = req_i.data;
                    MAN_POS1_OFS:  st_d.man1      = req_i.data;
                    default:       st_d.cfg       = st_q.cfg;
                endcase
            end
        end
        // Entry holds two independent full-range bytes
        if (st_q.cfg[CFG_TEMP_EN_BIT]) begin
            st_d.pos.pos0 = lut0_mem[7'(lut_idx - LUT_IDX_MIN)];
            st_d.pos.pos1 = lut1_mem[7'(lut_idx - LUT_IDX_MIN)];
        end else begin
            st_d.pos.pos0 = st_q.man0;
            st_d.pos.pos1 = st_q.man1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q <= '{tbl_sel: TBL_CONFIG, cfg: CFG_RESET, prog_addr: MAIN_ADDR_DFLT,
                      man0: 8'h00, man1: 8'h00, pos: '0, ack: 1'b0, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // Array storage; not reset, as EEPROM content persists across a logic reset
    always_ff @(posedge mclk_i) begin
        if (wr_ok_c && hit_aux_w) begin
            aux_mem[lo7] <= req_i.data;
        end
        if (wr_ok_c && hit_main_w) begin
            if (!req_i.offset[7] && req_i.offset < SRAM_LO) begin
                main_mem[lo7] <= req_i.data;
            end else if (!req_i.offset[7]) begin
                sram_mem[5'(lo7 - 7'h60)] <= req_i.data;
            end else if (st_q.tbl_sel == TBL_EXTRA) begin
                extra_mem[lo7] <= req_i.data;
            end else if (st_q.tbl_sel == TBL_CONFIG) begin
                cfg_mem[lo7] <= req_i.data;
            end else if (lo7 < 7'h48 && st_q.tbl_sel == TBL_LUT0) begin
                lut0_mem[lo7] <= req_i.data;
            end else if (lo7 < 7'h48) begin
                lut1_mem[lo7] <= req_i.data;
            end
        end
    end

    // *********************************
    // Read path
    // *********************************
    always_comb begin
        logic [1:0] h;
        logic [6:0] r7;
        h         = dev_hit(rd_dev_i, st_q.cfg, st_q.prog_addr);
        r7        = rd_ofs_i[6:0];
        rd_data_o = 8'h00;
        rd_hit_o  = h != 2'b00;
        if (h[0]) begin
            rd_data_o = rd_ofs_i[7] ? 8'h00 : aux_mem[r7];
        end else if (h[1]) begin
            case (rd_ofs_i)
                8'h60:   rd_data_o = temp_i[15:8];
                8'h61:   rd_data_o = temp_i[7:0];
                8'h64:   rd_data_o = ext_monitor_a_i[15:8];
                8'h65:   rd_data_o = ext_monitor_a_i[7:0];
                8'h66:   rd_data_o = ext_monitor_b_i[15:8];
                8'h67:   rd_data_o = ext_monitor_b_i[7:0];
                8'h68:   rd_data_o = ext_monitor_c_i[15:8];
                8'h69:   rd_data_o = ext_monitor_c_i[7:0];
                TABLE_SEL_OFS: rd_data_o = st_q.tbl_sel;
                default: begin
                    if (!rd_ofs_i[7]) begin
                        rd_data_o = (rd_ofs_i < SRAM_LO) ? main_mem[r7] : sram_mem[5'(r7 - 7'h60)];
                    end else if (st_q.tbl_sel == TBL_EXTRA && single_c) begin
                        rd_data_o = extra_mem[r7];
                    end else if (st_q.tbl_sel == TBL_CONFIG) begin
                        case (rd_ofs_i)
                            PROT_CFG_OFS:  rd_data_o = st_q.cfg;
                            PROG_ADDR_OFS: rd_data_o = st_q.prog_addr;
                            MAN_POS0_OFS:  rd_data_o = st_q.man0;
                            MAN_POS1_OFS:  rd_data_o = st_q.man1;
                            default:       rd_data_o = cfg_mem[r7];
                        endcase
                    end else if (r7 < 7'h48 && st_q.tbl_sel == TBL_LUT0) begin
                        rd_data_o = lut0_mem[r7];
                    end else if (r7 < 7'h48 && st_q.tbl_sel == TBL_LUT1) begin
                        rd_data_o = lut1_mem[r7];
                    end
                end
            endcase
        end
    end

    assign wr_ack_o    = st_q.ack;
    assign wr_done_o   = st_q.done;
    assign pos_o       = st_q.pos;
    assign main_addr_o = main_addr_c;

    // *********************************
    // Checks
    // *********************************
    main_prot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        hit_main_w && pin_lvl && st_q.cfg[CFG_MAINPROT_BIT] && req_i.offset < SRAM_LO |=> !wr_done_o)
        else $error("protected main write landed");
    aux_prot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        hit_aux_w && st_q.cfg[CFG_AUXPROT_BIT] |=> !wr_done_o)
        else $error("protected aux write landed");
    sram_open_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        hit_main_w && req_i.offset >= 8'h6a && req_i.offset <= 8'h7f |=> wr_done_o)
        else $error("sram write refused");
    ack_prot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (hit_main_w || hit_aux_w) |=> wr_ack_o)
        else $error("addressed write not acknowledged");
    cfg_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !hit_main_w |=> st_q.cfg == $past(st_q.cfg))
        else $error("config changed without main write");
    single_aux_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        st_q.cfg[CFG_SINGLE_BIT] && rd_dev_i[7:1] == AUX_ADDR[7:1] && main_addr_o[7:1] != AUX_ADDR[7:1]
        |-> !rd_hit_o)
        else $error("aux answered in single mode");
    main_addr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !st_q.cfg[CFG_PROGADR_BIT] |-> main_addr_o == MAIN_ADDR_DFLT)
        else $error("fixed main address wrong");
    manual_pos_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !st_q.cfg[CFG_TEMP_EN_BIT] ##1 !st_q.cfg[CFG_TEMP_EN_BIT] |-> pos_o.pos0 == $past(st_q.man0))
        else $error("manual position not applied");
    ro_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        hit_main_w && req_i.offset == 8'h60 |=> !wr_done_o)
        else $error("read-only byte written");

    cov_main_wr_c:   cover property (@(posedge mclk_i) hit_main_w && wr_ok_c);
    cov_blocked_c:   cover property (@(posedge mclk_i) hit_main_w && !wr_ok_c);
    cov_aux_wr_c:    cover property (@(posedge mclk_i) hit_aux_w && wr_ok_c);
    cov_temp_mode_c: cover property (@(posedge mclk_i) st_q.cfg[CFG_TEMP_EN_BIT] && lut_idx == LUT_IDX_MAX);

endmodule

/* tlw_host_model.sv */
// Bus host model that issues byte writes and reads to the block
`timescale 1ns/1ps
module tlw_host_model
    import tlw_pkg::*;
(
    // Clock
    input  wire logic       mclk_i,
    // Answers from the block
    input  wire logic       wr_ack_i,
    input  wire logic       wr_done_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_hit_i,
    // Requests to the block
    output tlw_req_t        req_o,
    output logic [7:0]      rd_dev_o,
    output logic [7:0]      rd_ofs_o
);
    // Idle bus at time zero
    initial begin
        req_o    = '0;
        rd_dev_o = 8'h00;
        rd_ofs_o = 8'h00;
    end

    // One byte write; released fields go inverted so stale data never looks current
    task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
                      output logic ack, output logic done);
        @(posedge mclk_i);
        req_o <= '{valid: 1'b1, dev_addr: dev, offset: ofs, data: dat};
        @(posedge mclk_i);
        req_o <= '{valid: 1'b0, dev_addr: ~dev, offset: ~ofs, data: ~dat};
        #1;
        ack  = wr_ack_i;
        done = wr_done_i;
    endtask

    // Reads are combinational, so sample once the new address has landed
    task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, output logic [7:0] dat, output logic hit);
        @(posedge mclk_i);
        rd_dev_o <= dev;
        rd_ofs_o <= ofs;
        #1;
        dat = rd_data_i;
        hit = rd_hit_i;
    endtask
endmodule

/* test_temp_lut_address_write_protect.sv */
// Self-checking testbench for the temperature table and write-protect block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module test_temp_lut_address_write_protect;
    import tlw_pkg::*;
    // ************************************************
    // Signals and model state
    // ************************************************
    logic        mclk_i, sys_rst_i, protect_pin_i, rd_hit, a, d, h, p, mp, ap, a_w, d_w;
    tlw_req_t    req;
    tlw_pos_t    pos;
    logic [7:0]  rd_dev, rd_ofs, rd_data, main_addr, rb, dt, em, r0, r1;
    logic [15:0] temp_i, mon_a, mon_b, mon_c;
    logic [7:0]  lut0 [72];
    logic [7:0]  lut1 [72];
    int          err_count, samples_checked, deg, ix;
    int          tlist [10] = '{-128, -41, -40, -39, -38, 0, 101, 102, 103, 127};

    tlw_core dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rd_dev_i(rd_dev),
        .rd_ofs_i(rd_ofs), .rd_data_o(rd_data), .rd_hit_o(rd_hit), .wr_ack_o(a_w), .wr_done_o(d_w),
        .protect_pin_i(protect_pin_i), .temp_i(temp_i), .ext_monitor_a_i(mon_a),
        .ext_monitor_b_i(mon_b), .ext_monitor_c_i(mon_c), .pos_o(pos), .main_addr_o(main_addr));
    tlw_host_model host (.mclk_i(mclk_i), .wr_ack_i(a_w), .wr_done_i(d_w), .rd_data_i(rd_data),
        .rd_hit_i(rd_hit), .req_o(req), .rd_dev_o(rd_dev), .rd_ofs_o(rd_ofs));

    // 200 MHz clock
    initial mclk_i = 1'b0;
    always #2.5 mclk_i = ~mclk_i;

    // Short helpers for one write and for a pin change that outlasts the synchroniser
    task automatic w(input logic [7:0] dv, input logic [7:0] of, input logic [7:0] dd);
        host.wr(dv, of, dd, a, d);
    endtask
    task automatic set_pin(input logic v);
        @(posedge mclk_i) protect_pin_i <= v;
        repeat (6) @(posedge mclk_i);
    endtask

    // Look-up index from whole degrees, clamped to the table
    function automatic int lut_idx(input int dg);
        if (dg < -40) return 0;
        return ((dg + 40) / 2 > 71) ? 71 : (dg + 40) / 2;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog: the tests need under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        wrap_up();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'h3c1c51a8));
        sys_rst_i = 1'b1;
        protect_pin_i = 1'b1;
        temp_i = 16'h0000;
        mon_a = 16'($urandom);
        mon_b = 16'($urandom);
        mon_c = 16'($urandom);
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Reset values of the configuration bytes
        host.rd(8'ha2, 8'h89, rb, h); `CHK("cfg", CFG_RESET, rb)
        host.rd(8'ha2, 8'h7f, rb, h); `CHK("tbl_sel", 8'h01, rb)
        host.rd(8'ha2, 8'h8c, rb, h); `CHK("prog_addr", 8'ha2, rb)
        `CHK("main_addr", 8'ha2, main_addr)
        // Readings, read-only bytes and the aux window limit
        host.rd(8'ha2, 8'h60, rb, h); `CHK("temp_hi", temp_i[15:8], rb)
        host.rd(8'ha2, 8'h65, rb, h); `CHK("mon_a_lo", mon_a[7:0], rb)
        host.rd(8'ha2, 8'h66, rb, h); `CHK("mon_b_hi", mon_b[15:8], rb)
        host.rd(8'ha2, 8'h69, rb, h); `CHK("mon_c_lo", mon_c[7:0], rb)
        w(8'ha2, 8'h60, 8'h5a); `CHK("ro_ack", 1'b1, a)
        `CHK("ro_done", 1'b0, d)
        // Aux cannot reach the protect bits: addressed, so answered, but dropped
        w(8'ha0, 8'h89, 8'h1f); `CHK("aux_cfg_ack", 1'b1, a)
        `CHK("aux_cfg_done", 1'b0, d)
        host.rd(8'ha2, 8'h89, rb, h); `CHK("aux_cfg_kept", CFG_RESET, rb)
        $display("test reset and readings done");
        // Every pin and protect-bit combination
        for (int c = 0; c < 8; c++) begin
            p = c[0];
            mp = c[1];
            ap = c[2];
            set_pin(1'b0);
            w(8'ha2, 8'h89, {3'b000, mp, ap, 3'b001});
            set_pin(p);
            dt = 8'($urandom);
            w(8'ha2, 8'h00, dt); `CHK("main_done", !(p && mp), d)
            if (!(p && mp)) em = dt;
            host.rd(8'ha2, 8'h00, rb, h); `CHK("main_data", em, rb)
            w(8'ha0, 8'h10, dt); `CHK("aux_done", !ap, d)
            w(8'ha2, 8'h6a, dt); `CHK("sram_done", 1'b1, d)
        end
        $display("test protection done");
        // Single-address mode: table 00 follows the aux bit only
        for (int c = 0; c < 2; c++) begin
            set_pin(1'b0);
            w(8'ha2, 8'h89, {4'b0000, c[0], 3'b010});
            set_pin(1'b1);
            host.rd(8'ha0, 8'h00, rb, h); `CHK("aux_hit", 1'b0, h)
            w(8'ha2, 8'h7f, TBL_EXTRA);
            w(8'ha2, 8'h80, 8'h3c); `CHK("tbl00_done", !c[0], d)
            w(8'ha2, 8'h7f, TBL_CONFIG); `CHK("tsel_done", 1'b1, d)
        end
        // Programmed main address
        w(8'ha2, 8'h8c, 8'hb4);
        w(8'ha2, 8'h89, 8'h04); `CHK("main_addr", 8'hb4, main_addr)
        host.rd(8'ha2, 8'h00, rb, h); `CHK("old_hit", 1'b0, h)
        host.rd(8'ha0, 8'h00, rb, h); `CHK("aux_hit", 1'b1, h)
        // Manual positions with indexing off
        r0 = 8'($urandom);
        r1 = 8'($urandom);
        w(8'hb4, 8'h82, r0); `CHK("prog_ack", 1'b1, a)
        w(8'hb4, 8'h83, r1);
        w(8'hb4, 8'h89, 8'h00);
        repeat (3) @(posedge mclk_i);
        #1 `CHK("man_pos0", r0, pos.pos0)
        `CHK("man_pos1", r1, pos.pos1)
        // Config 00h dropped the programmed address, so the fixed one answers now
        w(8'ha2, 8'h89, 8'h01); `CHK("ten_done", 1'b1, d)
        $display("test addressing and manual done");
        // Fill both look-up tables, then sweep temperatures
        for (int t = 2; t < 4; t++) begin
            w(8'ha2, 8'h7f, t[7:0]);
            for (int i = 0; i < 72; i++) begin
                dt = 8'($urandom);
                if (t == 2) lut0[i] = dt;
                else lut1[i] = dt;
                w(8'ha2, 8'h80 + i[7:0], dt);
            end
        end
        w(8'ha2, 8'h7f, TBL_CONFIG);
        for (int k = 0; k < 16; k++) begin
            deg = (k < 10) ? tlist[k] : int'($urandom_range(255)) - 128;
            @(posedge mclk_i) temp_i <= {deg[7:0], 8'($urandom)};
            repeat (4) @(posedge mclk_i);
            ix = lut_idx(deg);
            #1 `CHK("lut_pos0", lut0[ix], pos.pos0)
            `CHK("lut_pos1", lut1[ix], pos.pos1)
        end
        $display("test look-up done");
        wrap_up();
    end
endmodule
